// >>> cdp_core.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - 32 byte registers, operate and write back per cycle
// - Registers 30 and 31 form a 16-bit pointer
// - Indirect register access uses pointer low five bits only
// - Immediate ops reach only registers 16 to 31
// - Fetch next word while current one executes
// - Each instruction is one 16-bit word
// - 512-word program space, nine-bit program counter
// - Three-level nine-bit hardware return stack
// - Call or interrupt pushes into level zero
// - Return pops level zero, shifts levels up
// - Oldest lost on overflow, deepest repeats on pop
// - I/O ops carry a six-bit address
// - Relative branch goes to pc plus offset plus one
// - Constant load: pointer word address, LSB picks byte
// - Two-register ops read both, write destination except compare (CP)
// - ALU does register, immediate, single-register operations
// - Lowest vector pending interrupt served first
// - Core runs straight off the system clock
// - Interrupt entry clears enable, interrupt return sets it
module cdp_core
   import cdp_pkg::*;
#(
   parameter int N_IRQ = IRQ_COUNT
)(
   input  wire logic                 i_clk,
   input  wire logic                 i_arst_n,
   output logic      [PC_W-1:0]      o_pm_addr,
   input  wire logic [INSN_W-1:0]    i_pm_data,
   output logic      [IO_ADDR_W-1:0] o_io_addr,
   output logic      [DATA_W-1:0]    o_io_wdata,
   output logic                      o_io_we,
   output logic                      o_io_re,
   input  wire logic [DATA_W-1:0]    i_io_rdata,
   input  wire logic [N_IRQ-1:0]     i_irq_req,
   output logic                      o_irq_ack,
   output logic      [PC_W-1:0]      o_irq_vector,
   output logic                      o_gie,
   output logic                      o_carry,
   output logic                      o_zero,
   output logic      [PC_W-1:0]      o_exec_pc
);

   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_LPM = 1'b1
   } cdp_state_type;

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Decode one instruction word into ALU function, class and operand selects
   function automatic cdp_dec_type decode(input logic [INSN_W-1:0] w);
      cdp_dec_type d;
      d                 = '0;
      d.cls             = CL_NOP;
      d.fn              = ALU_PASS;
      d.rd              = f_rd(w);
      d.source_register = f_rr(w);
      d.imm             = f_imm(w);
      if (w == SUBROUTINE_RETURN_OP)
         d.cls = CL_RET;
      else if (w == INTERRUPT_RETURN_OP)
         d.cls = CL_INTERRUPT_RETURN_OP;
      else if (w == PROGRAM_CONSTANT_LOAD_OP)
         d.cls = CL_LPM;
      else if (w == SET_GIE_OP)
         d.cls = CL_SEI;
      else if (w == CLEAR_GIE_OP)
         d.cls = CL_CLI;
      else if (f_nib(w) >= COMPARE_IMMEDIATE_OP && f_nib(w) <= AND_IMMEDIATE_OP
               || f_nib(w) == LOAD_IMMEDIATE_OP)
      begin
         d.cls     = CL_ALU;
         d.rd      = f_rd_hi(w);
         d.use_imm = 1'b1;
         d.wb      = 1'b1;
         d.upd_z   = 1'b1;
         case (f_nib(w))
            COMPARE_IMMEDIATE_OP   : begin d.fn = ALU_SUB; d.wb = 1'b0; d.upd_c = 1'b1; end
            SUB_CARRY_IMMEDIATE_OP : begin d.fn = ALU_SBC; d.upd_c = 1'b1; end
            SUB_IMMEDIATE_OP       : begin d.fn = ALU_SUB; d.upd_c = 1'b1; end
            OR_IMMEDIATE_OP        : d.fn = ALU_OR;
            AND_IMMEDIATE_OP       : d.fn = ALU_AND;
            default                : begin d.fn = ALU_PASS; d.upd_z = 1'b0; end
         endcase
      end
      else if (f_nib(w) == RELATIVE_JUMP_OP)
         d.cls = CL_JMP;
      else if (f_nib(w) == RELATIVE_CALL_OP)
         d.cls = CL_CALL;
      else if (f_top5(w) == IO_IN_OP)
         d.cls = CL_IN;
      else if (f_top5(w) == IO_OUT_OP)
         d.cls = CL_OUT;
      else if (f_top7(w) == LD_Z_GROUP && f_low4(w) == IND_SUB)
         d.cls = CL_LD;
      else if (f_top7(w) == ST_Z_GROUP && f_low4(w) == IND_SUB)
         d.cls = CL_ST;
      else if (f_top7(w) == ONE_GROUP)
      begin
         d.cls   = CL_ALU;
         d.wb    = 1'b1;
         d.upd_z = 1'b1;
         d.upd_c = 1'b1;
         case (f_low4(w))
            4'h0    : d.fn = ALU_COM;
            4'h1    : d.fn = ALU_NEG;
            4'h2    : begin d.fn = ALU_SWAP; d.upd_z = 1'b0; d.upd_c = 1'b0; end
            4'h3    : begin d.fn = ALU_INC; d.upd_c = 1'b0; end
            4'h5    : d.fn = ALU_ASR;
            4'h6    : d.fn = ALU_LSR;
            4'h7    : d.fn = ALU_ROR;
            4'hA    : begin d.fn = ALU_DEC; d.upd_c = 1'b0; end
            default : begin d.cls = CL_NOP; d.wb = 1'b0; end
         endcase
      end
      else
      begin
         d.cls   = CL_ALU;
         d.wb    = 1'b1;
         d.upd_z = 1'b1;
         case (f_top6(w))
            TWO_ADD : begin d.fn = ALU_ADD; d.upd_c = 1'b1; end
            TWO_ADC : begin d.fn = ALU_ADC; d.upd_c = 1'b1; end
            TWO_SUB : begin d.fn = ALU_SUB; d.upd_c = 1'b1; end
            TWO_SBC : begin d.fn = ALU_SBC; d.upd_c = 1'b1; end
            TWO_CP  : begin d.fn = ALU_SUB; d.upd_c = 1'b1; d.wb = 1'b0; end
            TWO_AND : d.fn = ALU_AND;
            TWO_OR  : d.fn = ALU_OR;
            TWO_EOR : d.fn = ALU_EOR;
            TWO_MOV : begin d.fn = ALU_PASS; d.upd_z = 1'b0; end
            default : begin d.cls = CL_NOP; d.wb = 1'b0; d.upd_z = 1'b0; end
         endcase
      end
      return d;
   endfunction

   // ALU: carry or borrow out in the top bit, result below
   function automatic logic [DATA_W:0] alu(input cdp_alu_fn_type fn, input logic [DATA_W-1:0] a,
                                           input logic [DATA_W-1:0] b, input logic cin);
      logic [DATA_W:0] r;
      r = '0;
      case (fn)
         ALU_ADD  : r = {1'b0, a} + {1'b0, b};
         ALU_ADC  : r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         ALU_SUB  : r = {1'b0, a} - {1'b0, b};
         ALU_SBC  : r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         ALU_AND  : r = {cin, a & b};
         ALU_OR   : r = {cin, a | b};
         ALU_EOR  : r = {cin, a ^ b};
         ALU_PASS : r = {cin, b};
         ALU_COM  : r = {1'b1, ~a};
         ALU_NEG  : r = 9'h000 - {1'b0, a};
         ALU_SWAP : r = {cin, a[3:0], a[7:4]};
         ALU_INC  : r = {cin, a + 8'h01};
         ALU_DEC  : r = {cin, a - 8'h01};
         ALU_ASR  : r = {a[0], a[7], a[7:1]};
         ALU_LSR  : r = {a[0], 1'b0, a[7:1]};
         ALU_ROR  : r = {a[0], cin, a[7:1]};
         default  : r = {cin, a};
      endcase
      return r;
   endfunction

   // Relative target, offset wraps over the whole program space
   function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc, input logic [11:0] k);
      return pc + k[PC_W-1:0] + PC_STEP;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State and wiring

   cdp_state_type         state_r, state_nxt;
   logic [PC_W-1:0]       pm_addr_r, pm_addr_nxt;
   logic [INSN_W-1:0]     ir_r;
   logic                  ir_valid_r, load_ir;
   logic [PC_W-1:0]       ex_pc_r;
   logic [PC_W-1:0]       resume_r;
   logic                  gie_r, carry_r, zero_r;
   logic                  irq_ack_r;
   logic [PC_W-1:0]       irq_vector_r;
   cdp_dec_type           dec;
   logic                  irq_take, exec;
   logic [PC_W-1:0]       irq_vec;
   logic [REG_ADDR_W-1:0] rb_addr, rf_waddr;
   logic [DATA_W-1:0]     rf_a, rf_b, op_b, rf_wdata;
   logic [2*DATA_W-1:0]   z_ptr;
   logic                  rf_we;
   logic [DATA_W:0]       alu_out;
   logic                  st_push, st_pop;
   logic [PC_W-1:0]       st_data, st_top;

   cdp_reg_file #(
      .N_REGS (REG_COUNT)
   ) u_regs (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_addr_a (dec.rd),
      .i_addr_b (rb_addr),
      .o_data_a (rf_a),
      .o_data_b (rf_b),
      .o_z      (z_ptr),
      .i_we     (rf_we),
      .i_waddr  (rf_waddr),
      .i_wdata  (rf_wdata)
   );

   cdp_ret_stack #(
      .LEVELS (STACK_LVLS),
      .WIDTH  (PC_W)
   ) u_stack (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_push   (st_push),
      .i_pop    (st_pop),
      .i_data   (st_data),
      .o_top    (st_top)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt priority: lowest index, thus lowest vector, wins
   always_comb
   begin
      irq_vec = IRQ_VECTOR_BASE;
      for (int i = N_IRQ - 1; i >= 0; i--)
         if (i_irq_req[i])
            irq_vec = IRQ_VECTOR_BASE + PC_W'(i);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Execute stage: decode, operand select, ALU, write-back and next fetch address
   always_comb
   begin
      dec      = decode(ir_r);
      irq_take = (state_r == ST_RUN) && ir_valid_r && gie_r && (|i_irq_req);
      exec     = (state_r == ST_RUN) && ir_valid_r && !irq_take;
      rb_addr  = (dec.cls == CL_LD) ? z_ptr[REG_ADDR_W-1:0] : dec.source_register;
      op_b     = dec.use_imm ? dec.imm : rf_b;
      alu_out  = alu(dec.fn, rf_a, op_b, carry_r);
      rf_we       = 1'b0;
      rf_waddr    = dec.rd;
      rf_wdata    = alu_out[DATA_W-1:0];
      st_push     = 1'b0;
      st_pop      = 1'b0;
      st_data     = ex_pc_r + PC_STEP;
      pm_addr_nxt = pm_addr_r + PC_STEP;
      load_ir     = 1'b1;
      state_nxt   = state_r;
      o_io_we     = 1'b0;
      o_io_re     = 1'b0;
      if (irq_take)
      begin
         // The held instruction is abandoned and resumed on return
         st_push     = 1'b1;
         st_data     = ex_pc_r;
         pm_addr_nxt = irq_vec;
         load_ir     = 1'b0;
      end
      else if (state_r == ST_LPM)
      begin
         // Memory now shows the constant word; pick the byte by pointer LSB
         rf_we       = 1'b1;
         rf_waddr    = LPM_DEST_REG;
         rf_wdata    = z_ptr[0] ? i_pm_data[INSN_W-1:DATA_W] : i_pm_data[DATA_W-1:0];
         pm_addr_nxt = resume_r;
         load_ir     = 1'b0;
         state_nxt   = ST_RUN;
      end
      else if (exec)
      begin
         case (dec.cls)
            CL_ALU  : rf_we = dec.wb;
            CL_IN   :
            begin
               rf_we    = 1'b1;
               rf_wdata = i_io_rdata;
               o_io_re  = 1'b1;
            end
            CL_OUT  : o_io_we = 1'b1;
            CL_LD   :
            begin
               rf_we    = 1'b1;
               rf_wdata = rf_b;
            end
            CL_ST   :
            begin
               rf_we    = 1'b1;
               rf_waddr = z_ptr[REG_ADDR_W-1:0];
               rf_wdata = rf_a;  // Stored register sits in the destination field
            end
            CL_JMP  :
            begin
               pm_addr_nxt = rel_target(ex_pc_r, f_k(ir_r));
               load_ir     = 1'b0;
            end
            CL_CALL :
            begin
               st_push     = 1'b1;
               pm_addr_nxt = rel_target(ex_pc_r, f_k(ir_r));
               load_ir     = 1'b0;
            end
            CL_RET, CL_INTERRUPT_RETURN_OP :
            begin
               st_pop      = 1'b1;
               pm_addr_nxt = st_top;
               load_ir     = 1'b0;
            end
            CL_LPM  :
            begin
               // Borrow the fetch port for one cycle, then refetch the next word
               pm_addr_nxt = z_ptr[PC_W:1];
               load_ir     = 1'b0;
               state_nxt   = ST_LPM;
            end
            default : rf_we = 1'b0;
         endcase
      end
   end

   // I/O address comes straight from the held instruction, write data from its destination-field register
   assign o_io_addr  = f_io(ir_r);
   assign o_io_wdata = rf_a;

   ////////////////////////////////////////////////////////////////////////////////
   // Fetch stage: runs on every rising edge of the undivided system clock
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         pm_addr_r  <= RESET_VECTOR;
         ir_r       <= '0;
         ir_valid_r <= 1'b0;
         ex_pc_r    <= RESET_VECTOR;
         state_r    <= ST_RUN;
      end
      else
      begin
         pm_addr_r  <= pm_addr_nxt;
         state_r    <= state_nxt;
         ir_valid_r <= load_ir;  // A redirect leaves one empty slot
         if (load_ir)
         begin
            ir_r    <= i_pm_data;
            ex_pc_r <= pm_addr_r;
         end
      end
   end

   // Fetch address to come back to after a constant load
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         resume_r <= RESET_VECTOR;
      else if (exec && dec.cls == CL_LPM)
         resume_r <= pm_addr_r;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Flags and global interrupt enable
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         carry_r <= 1'b0;
         zero_r  <= 1'b0;
      end
      else if (exec && dec.cls == CL_ALU)
      begin
         if (dec.upd_c)
            carry_r <= alu_out[DATA_W];
         // Chained subtract only keeps zero if every byte was zero
         if (dec.upd_z)
            zero_r <= (alu_out[DATA_W-1:0] == '0) && (dec.fn != ALU_SBC || zero_r);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         gie_r <= 1'b0;
      else if (irq_take)
         gie_r <= 1'b0;
      else if (exec && (dec.cls == CL_INTERRUPT_RETURN_OP || dec.cls == CL_SEI))
         gie_r <= 1'b1;
      else if (exec && dec.cls == CL_CLI)
         gie_r <= 1'b0;
   end

   // Acknowledge is a registered pulse one cycle after the interrupt is taken
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         irq_ack_r    <= 1'b0;
         irq_vector_r <= RESET_VECTOR;
      end
      else
      begin
         irq_ack_r <= irq_take;
         if (irq_take)
            irq_vector_r <= irq_vec;
      end
   end

   assign o_pm_addr    = pm_addr_r;
   assign o_irq_ack    = irq_ack_r;
   assign o_irq_vector = irq_vector_r;
   assign o_gie        = gie_r;
   assign o_carry      = carry_r;
   assign o_zero       = zero_r;
   assign o_exec_pc    = ex_pc_r;

endmodule
`default_nettype wire

// >>> cdp_pkg.sv
package cdp_pkg;

   // Core geometry
   localparam int REG_COUNT  = 32;
   localparam int REG_ADDR_W = 5;
   localparam int DATA_W     = 8;
   localparam int INSN_W     = 16;
   localparam int PC_W       = 9;
   localparam int PM_WORDS   = 512;
   localparam int IO_ADDR_W  = 6;
   localparam int STACK_LVLS = 3;
   localparam int IRQ_COUNT  = 8;

   // Pointer pair and fixed register roles
   localparam logic [REG_ADDR_W-1:0] Z_LOW_REG    = 5'h1E;
   localparam logic [REG_ADDR_W-1:0] Z_HIGH_REG   = 5'h1F;
   localparam logic [REG_ADDR_W-1:0] LPM_DEST_REG = 5'h00;
   localparam logic                  IMM_REG_HALF = 1'h1;

   // Reset and vector addresses
   localparam logic [PC_W-1:0] RESET_VECTOR    = 9'h000;
   localparam logic [PC_W-1:0] IRQ_VECTOR_BASE = 9'h001;
   localparam logic [PC_W-1:0] PC_STEP         = 9'h001;

   // Whole-word opcodes
   localparam logic [15:0] SUBROUTINE_RETURN_OP     = 16'h9508;
   localparam logic [15:0] INTERRUPT_RETURN_OP      = 16'h9518;
   localparam logic [15:0] PROGRAM_CONSTANT_LOAD_OP = 16'h95C8;
   localparam logic [15:0] SET_GIE_OP               = 16'h9478;
   localparam logic [15:0] CLEAR_GIE_OP             = 16'h94F8;

   // Top-nibble opcodes
   localparam logic [3:0] COMPARE_IMMEDIATE_OP   = 4'h3;
   localparam logic [3:0] SUB_CARRY_IMMEDIATE_OP = 4'h4;
   localparam logic [3:0] SUB_IMMEDIATE_OP       = 4'h5;
   localparam logic [3:0] OR_IMMEDIATE_OP        = 4'h6;
   localparam logic [3:0] AND_IMMEDIATE_OP       = 4'h7;
   localparam logic [3:0] RELATIVE_JUMP_OP       = 4'hC;
   localparam logic [3:0] RELATIVE_CALL_OP       = 4'hD;
   localparam logic [3:0] LOAD_IMMEDIATE_OP      = 4'hE;

   // Two-register opcodes (top six bits)
   localparam logic [5:0] TWO_SBC = 6'h02;
   localparam logic [5:0] TWO_ADD = 6'h03;
   localparam logic [5:0] TWO_CP  = 6'h05;
   localparam logic [5:0] TWO_SUB = 6'h06;
   localparam logic [5:0] TWO_ADC = 6'h07;
   localparam logic [5:0] TWO_AND = 6'h08;
   localparam logic [5:0] TWO_EOR = 6'h09;
   localparam logic [5:0] TWO_OR  = 6'h0A;
   localparam logic [5:0] TWO_MOV = 6'h0B;

   // Single-register group, indirect and I/O groups
   localparam logic [6:0] ONE_GROUP  = 7'h4A;
   localparam logic [6:0] LD_Z_GROUP = 7'h40;
   localparam logic [6:0] ST_Z_GROUP = 7'h41;
   localparam logic [3:0] IND_SUB    = 4'h0;
   localparam logic [4:0] IO_IN_OP   = 5'h16;
   localparam logic [4:0] IO_OUT_OP  = 5'h17;

   typedef enum logic [3:0] {
      ALU_ADD  = 4'b0000, ALU_ADC = 4'b0001, ALU_SUB  = 4'b0010, ALU_SBC = 4'b0011,
      ALU_AND  = 4'b0100, ALU_OR  = 4'b0101, ALU_EOR  = 4'b0110, ALU_PASS = 4'b0111,
      ALU_COM  = 4'b1000, ALU_NEG = 4'b1001, ALU_SWAP = 4'b1010, ALU_INC = 4'b1011,
      ALU_ASR  = 4'b1100, ALU_LSR = 4'b1101, ALU_ROR  = 4'b1110, ALU_DEC = 4'b1111
   } cdp_alu_fn_type;

   typedef enum logic [3:0] {
      CL_NOP  = 4'b0000, CL_ALU  = 4'b0001, CL_IN  = 4'b0010, CL_OUT = 4'b0011,
      CL_LD   = 4'b0100, CL_ST   = 4'b0101, CL_JMP = 4'b0110, CL_CALL = 4'b0111,
      CL_RET  = 4'b1000, CL_INTERRUPT_RETURN_OP = 4'b1001, CL_LPM = 4'b1010, CL_SEI = 4'b1011,
      CL_CLI  = 4'b1100
   } cdp_class_type;

   // Decoded instruction
   typedef struct packed {
      cdp_class_type         cls;
      cdp_alu_fn_type        fn;
      logic [REG_ADDR_W-1:0] rd;
      logic [REG_ADDR_W-1:0] source_register;
      logic                  use_imm;
      logic [DATA_W-1:0]     imm;
      logic                  wb;
      logic                  upd_c;
      logic                  upd_z;
   } cdp_dec_type;

   // Instruction field extraction
   function automatic logic [3:0] f_nib(input logic [15:0] w);
      return w[15:12];
   endfunction
   function automatic logic [5:0] f_top6(input logic [15:0] w);
      return w[15:10];
   endfunction
   function automatic logic [6:0] f_top7(input logic [15:0] w);
      return w[15:9];
   endfunction
   function automatic logic [4:0] f_top5(input logic [15:0] w);
      return w[15:11];
   endfunction
   function automatic logic [3:0] f_low4(input logic [15:0] w);
      return w[3:0];
   endfunction
   function automatic logic [4:0] f_rd(input logic [15:0] w);
      return w[8:4];
   endfunction
   function automatic logic [4:0] f_rr(input logic [15:0] w);
      return {w[9], w[3:0]};
   endfunction
   function automatic logic [4:0] f_rd_hi(input logic [15:0] w);
      return {IMM_REG_HALF, w[7:4]};
   endfunction
   function automatic logic [7:0] f_imm(input logic [15:0] w);
      return {w[11:8], w[3:0]};
   endfunction
   function automatic logic [5:0] f_io(input logic [15:0] w);
      return {w[10:9], w[3:0]};
   endfunction
   function automatic logic [11:0] f_k(input logic [15:0] w);
      return w[11:0];
   endfunction

endpackage

// >>> cdp_reg_file.sv
`timescale 1ns/1ns
`default_nettype none
module cdp_reg_file
   import cdp_pkg::*;
#(
   parameter int N_REGS = REG_COUNT
)(
   input  wire logic                  i_clk,
   input  wire logic                  i_arst_n,
   input  wire logic [REG_ADDR_W-1:0] i_addr_a,
   input  wire logic [REG_ADDR_W-1:0] i_addr_b,
   output logic      [DATA_W-1:0]     o_data_a,
   output logic      [DATA_W-1:0]     o_data_b,
   output logic      [2*DATA_W-1:0]   o_z,
   input  wire logic                  i_we,
   input  wire logic [REG_ADDR_W-1:0] i_waddr,
   input  wire logic [DATA_W-1:0]     i_wdata
);
   logic [DATA_W-1:0] regs_r [N_REGS];

   // Reads are combinational so operand fetch and write-back fit one cycle
   assign o_data_a = regs_r[i_addr_a];
   assign o_data_b = regs_r[i_addr_b];
   assign o_z      = {regs_r[Z_HIGH_REG], regs_r[Z_LOW_REG]};

   // One write port, result lands at the clock edge ending the operation
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         for (int i = 0; i < N_REGS; i++)
            regs_r[i] <= '0;
      end
      else if (i_we)
      begin
         regs_r[i_waddr] <= i_wdata;
      end
   end
endmodule
`default_nettype wire

// >>> cdp_ret_stack.sv
`timescale 1ns/1ns
`default_nettype none
module cdp_ret_stack
   import cdp_pkg::*;
#(
   parameter int LEVELS = STACK_LVLS,
   parameter int WIDTH  = PC_W
)(
   input  wire logic             i_clk,
   input  wire logic             i_arst_n,
   input  wire logic             i_push,
   input  wire logic             i_pop,
   input  wire logic [WIDTH-1:0] i_data,
   output logic      [WIDTH-1:0] o_top
);
   logic [WIDTH-1:0] lvl_r [LEVELS];

   assign o_top = lvl_r[0];

   // Push shifts deeper and drops the oldest; pop shifts up and the deepest level keeps its value
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         for (int i = 0; i < LEVELS; i++)
            lvl_r[i] <= '0;
      end
      else if (i_push)
      begin
         lvl_r[0] <= i_data;
         for (int i = 1; i < LEVELS; i++)
            lvl_r[i] <= lvl_r[i-1];
      end
      else if (i_pop)
      begin
         for (int i = 0; i < LEVELS - 1; i++)
            lvl_r[i] <= lvl_r[i+1];
      end
   end
endmodule
`default_nettype wire

// >>> cdp_core_chk.sv
`timescale 1ns/1ns
`default_nettype none
module cdp_core_chk
   import cdp_pkg::*;
(
   input wire logic            i_clk,
   input wire logic            i_arst_n,
   input wire logic [PC_W-1:0] o_pm_addr,
   input wire logic            o_io_we,
   input wire logic            o_io_re,
   input wire logic            o_irq_ack,
   input wire logic [PC_W-1:0] o_irq_vector,
   input wire logic            o_gie
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   ////////////////////////////////////////
   // Strobes and the interrupt entry sequence
   a_io_one_dir: assert property (!(o_io_we && o_io_re))
      else $error("both io strobes high");
   a_entry_clears: assert property (o_irq_ack |-> $fell(o_gie))
      else $error("enable not cleared on entry");
   a_masked_wait: assert property (!o_gie |=> !o_irq_ack)
      else $error("interrupt taken while disabled");
   a_ack_single: assert property (o_irq_ack |=> !o_irq_ack)
      else $error("ack longer than one cycle");
   a_vec_range: assert property (o_irq_ack |-> o_irq_vector inside {[9'h001:9'h008]})
      else $error("vector out of table");
   a_vec_fetch: assert property (o_irq_ack |-> o_pm_addr == o_irq_vector)
      else $error("fetch not at vector");
   a_vec_step: assert property (o_irq_ack |=> o_pm_addr == $past(o_pm_addr) + 9'h001)
      else $error("no prefetch after vector");
   a_vec_hold: assert property (!o_irq_ack |-> $stable(o_irq_vector))
      else $error("vector moved without entry");
endmodule
`default_nettype wire

// >>> cdp_pm_model.sv
`timescale 1ns/1ns
`default_nettype none
module cdp_pm_model
   import cdp_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire logic [PC_W-1:0]      i_addr,
   output logic      [INSN_W-1:0]    o_data,
   input  wire logic [IO_ADDR_W-1:0] i_io_addr,
   input  wire logic [DATA_W-1:0]    i_io_wdata,
   input  wire logic                 i_io_we,
   input  wire logic                 i_io_re,
   output logic      [DATA_W-1:0]    o_io_rdata
);
   logic [INSN_W-1:0] mem [PM_WORDS];
   logic [DATA_W-1:0] io_r [64];
   // Async word read, one instruction per address
   assign o_data = mem[i_addr];
   // Idle bus shows the inverse so a stale byte never passes
   assign o_io_rdata = i_io_re ? io_r[i_io_addr] : ~io_r[i_io_addr];
   // I/O space write
   always_ff @(posedge i_clk) if (i_io_we) io_r[i_io_addr] <= i_io_wdata;
endmodule
`default_nettype wire

// >>> cdp_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
module cdp_core_bench;
   import cdp_pkg::*;
   logic                 clk = 1'b0;
   logic                 arst_n = 1'b0;
   logic [7:0]           irq = 8'h00;
   logic [PC_W-1:0]      pm_addr, vec, epc;
   logic [INSN_W-1:0]    pm_data;
   logic [IO_ADDR_W-1:0] io_addr;
   logic [DATA_W-1:0]    io_wdata, io_rdata;
   logic                 io_we, io_re, ack, gie, cy, zf;
   int                   bad_count = 0;
   int                   compares = 0;
   logic [13:0]          wq [$];
   ////////////////////////////////////////
   // 50 MHz clock
   always #10 clk = ~clk;
   cdp_core u_cdp_core (.i_clk(clk), .i_arst_n(arst_n), .o_pm_addr(pm_addr), .i_pm_data(pm_data),
      .o_io_addr(io_addr), .o_io_wdata(io_wdata), .o_io_we(io_we), .o_io_re(io_re), .i_io_rdata(io_rdata),
      .i_irq_req(irq), .o_irq_ack(ack), .o_irq_vector(vec), .o_gie(gie), .o_carry(cy), .o_zero(zf),
      .o_exec_pc(epc));
   cdp_pm_model u_cdp_pm_model (.i_clk(clk), .i_addr(pm_addr), .o_data(pm_data), .i_io_addr(io_addr),
      .i_io_wdata(io_wdata), .i_io_we(io_we), .i_io_re(io_re), .o_io_rdata(io_rdata));
   // Instruction words and expected vector
   function automatic logic [15:0] load_immediate_op(input logic [3:0] d, input logic [7:0] k);
      return {4'hE, k[7:4], d, k[3:0]};
   endfunction
   function automatic logic [15:0] outw(input logic [5:0] p, input logic [4:0] r);
      return {5'h17, p[5:4], r, p[3:0]};
   endfunction
   function automatic logic [PC_W-1:0] vec_of(input logic [7:0] m);
      for (int i = 7; i >= 0; i--)
         if (m[i]) vec_of = PC_W'(i + 1);
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task automatic close_out;
      if (bad_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Record every I/O write once settled
   always @(negedge clk) if (io_we === 1'b1) wq.push_back({io_addr, io_wdata});
   // Hang guard, runs take under 200 cycles
   initial
   begin
      #(20 * 2000);
      bad_count++;
      close_out();
   end
   // Four programs, first one at the corners
   initial
   begin
      logic [7:0]  a, b, m;
      logic [8:0]  s;
      logic [5:0]  p;
      logic [15:0] pg [19];
      int          n;
      void'($urandom(5080));
      foreach (u_cdp_pm_model.mem[i]) u_cdp_pm_model.mem[i] = 16'h0000;
      for (int r = 0; r < 4; r++)
      begin
         @(negedge clk);
         arst_n = 1'b0;
         a = (r == 0) ? 8'hFF : 8'($urandom);
         b = (r == 0) ? 8'h01 : 8'($urandom);
         p = (r == 0) ? 6'h3F : 6'($urandom);
         m = (r == 0) ? 8'h80 : 8'($urandom);
         if (m == 8'h00) m = 8'hFF;
         s = {1'b0, a} + {1'b0, b};
         pg = '{16'hC008, 0, 0, 0, 0, 0, 0, 0, 0, load_immediate_op(4'h0, a), load_immediate_op(4'h1, b), 16'h0F01, outw(p, 5'h10),
            16'hD003, outw(6'h01, 5'h11), SET_GIE_OP, 16'hCFFF, outw(6'h02, 5'h10), SUBROUTINE_RETURN_OP};
         foreach (pg[i]) u_cdp_pm_model.mem[i] = (i inside {[1:8]}) ? INTERRUPT_RETURN_OP : pg[i];
         repeat (4) @(negedge clk);
         wq.delete();
         arst_n = 1'b1;
         for (n = 0; n < 60 && gie !== 1'b1; n++) @(negedge clk);
         chk("io writes", 16'h0003, 16'(wq.size()));
         chk("sum out", {2'h0, p, a + b}, wq[0]);
         chk("sub out", {8'h02, a + b}, wq[1]);
         chk("ret out", {8'h01, b}, wq[2]);
         chk("carry", {15'h0000, s[8]}, {15'h0000, cy});
         chk("zero", {15'h0000, s[7:0] == 8'h00}, {15'h0000, zf});
         irq = m;
         for (n = 0; n < 20 && ack !== 1'b1; n++) @(negedge clk);
         irq = 8'h00;
         chk("vector", {7'h00, vec_of(m)}, {7'h00, vec});
         chk("gie off", 16'h0000, {15'h0000, gie});
         chk("held pc", 16'h0010, {7'h00, epc});
         for (n = 0; n < 20 && gie !== 1'b1; n++) @(negedge clk);
         chk("gie back", 16'h0001, {15'h0000, gie});
         chk("irq return", 16'h0010, {7'h00, pm_addr});
      end
      close_out();
   end
endmodule
bind cdp_core cdp_core_chk u_cdp_core_chk (.*);
`default_nettype wire
